// >>> shared/tacc_cfg.svh
// Overview of operation
// RQ1 - Starting a run sends the machine straight into sequence evaluation with no other command; the code does so only with group run as arm source.
// RQ2 - A fully satisfied sequence raises the arm toward the timing machine, scope and port out.
// RQ3 - A machine waiting for an arm ignores matching data until the arm arrives.
// RQ4 - An arriving arm enters a selectable sequence level, level 1 after reset; the code resets the arm level to level 0.
// RQ5 - The external arm input is taken on its rising edge; the sender must make that edge.
// RQ6 - The arm source of the machine is selectable: group run, port in or another machine.
// RQ7 - Each level stores every sample, no sample or only the samples of a chosen subset.
// RQ8 - Branching samples are stored by default, and a global option suppresses this.
// RQ9 - The branch option covers every branch together, never only some of them.
// RQ10 - Automatic and manual modes exist; branch and position choices act only in manual.
// RQ11 - In automatic mode the trigger lands near the middle of capture memory.
// RQ12 - Manual start, center and end put the trigger at the start, middle or end of memory.
// RQ13 - Delay, for a timing machine only, discards all samples until the delay has run out.
// RQ14 - A user defined position places the trigger at a programmed memory location.
// RQ15 - Memory wraps before the trigger and stops after the post-trigger sample count.
`ifndef TACC_CFG_SVH
`define TACC_CFG_SVH
`define TACC_AW 8
`define TACC_DW 32
`define TACC_MAW 12
`define TACC_DEPTH 13'h1000
`define TACC_LVLS 4
`define TACC_OFF_CTRL 8'h00
`define TACC_OFF_ARM 8'h04
`define TACC_OFF_POS 8'h08
`define TACC_OFF_DELAY 8'h0C
`define TACC_OFF_LEVEL 8'h10
`define TACC_OFF_STATUS 8'h14
`define TACC_OFF_IRQ_ST 8'h18
`define TACC_OFF_IRQ_MASK 8'h1C
`define TACC_CTRL_RUN 0
`define TACC_CTRL_MANUAL 1
`define TACC_CTRL_BR_OFF 2
`define TACC_CTRL_TIMING 3
`define TACC_IRQ_TRIG 0
`define TACC_IRQ_DONE 1
`define TACC_IRQ_ARM 2
`define TACC_RST_DELAY 32'h0000_0000
`define TACC_RST_LEVEL 10'h3FF
`endif

// >>> shared/tacc_pkg.sv
package tacc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_ARM,
        ST_SEQ,
        ST_DELAY,
        ST_POST,
        ST_DONE
    } tacc_state_t;
    // Trigger placement in capture memory
    typedef enum logic [2:0] {
        POS_START,
        POS_CENTER,
        POS_END,
        POS_DELAY,
        POS_USER
    } tacc_pos_t;
    // Where the arm of this machine comes from
    typedef enum logic [1:0] {
        ARM_GROUP_RUN,
        ARM_PORT_IN,
        ARM_MACHINE
    } tacc_arm_src_t;
    // Qualifier of what a level stores
    typedef enum logic [1:0] {
        QUAL_NONE,
        QUAL_ALL,
        QUAL_SUBSET
    } tacc_qual_t;
    typedef struct packed {
        logic we;
        logic [11:0] addr;
    } tacc_cap_t;
    typedef struct packed {
        logic valid;
        logic in_subset;
        logic [3:0] level_hit;
    } tacc_smp_t;
endpackage : tacc_pkg

// >>> core/tacc_arm_capture.sv
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "tacc_cfg.svh"
module tacc_arm_capture (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Sample qualification from the comparators
    input wire tacc_pkg::tacc_smp_t smp,
    // Arm inputs
    input wire logic port_in_pin,
    input wire logic arm_from_machine,
    // Arm outputs
    output logic arm_out,
    output logic port_out_pin,
    // Capture memory write side
    output tacc_pkg::tacc_cap_t cap,
    output logic [11:0] trig_addr,
    // Interrupt
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic manual;
    logic br_off;
    logic timing_mach;
    tacc_pkg::tacc_arm_src_t arm_src;
    logic [1:0] arm_lvl;
    tacc_pkg::tacc_pos_t pos_mode;
    logic [11:0] user_pos;
    logic [31:0] delay_len;
    logic [9:0] level_cfg;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic run_go;

    // Post-trigger count for each placement; auto falls back to center
    function automatic logic [11:0] post_count(input logic man, input tacc_pkg::tacc_pos_t pm,
                                               input logic [11:0] up);
        logic [12:0] depth;
        depth = `TACC_DEPTH;
        post_count = depth[12:1] - 12'h001; // [RQ11]
        if (man) begin
            case (pm)
                tacc_pkg::POS_START: post_count = depth[11:0] - 12'h001; // [RQ12]
                tacc_pkg::POS_END: post_count = 12'h000; // [RQ12]
                tacc_pkg::POS_DELAY: post_count = depth[11:0] - 12'h001;
                tacc_pkg::POS_USER: post_count = up; // [RQ14]
                default: post_count = depth[12:1] - 12'h001;
            endcase
        end
    endfunction : post_count

    // Store qualifier of a level
    function automatic tacc_pkg::tacc_qual_t level_qual(input logic [9:0] cfg,
                                                        input logic [1:0] lvl);
        logic [7:0] q;
        q = {cfg[7:0]};
        level_qual = tacc_pkg::tacc_qual_t'(q[lvl*2 +: 2]);
    endfunction : level_qual

    assign run_go = reg_wr && (reg_addr == `TACC_OFF_CTRL) && reg_wdata[`TACC_CTRL_RUN]; // [RQ1]

    // Software writes; the run bit is a pulse and not kept
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            manual <= 1'b0;
            br_off <= 1'b0;
            timing_mach <= 1'b0;
            arm_src <= tacc_pkg::ARM_GROUP_RUN;
            arm_lvl <= 2'h0; // [RQ4]
            pos_mode <= tacc_pkg::POS_CENTER;
            user_pos <= 12'h000;
            delay_len <= `TACC_RST_DELAY;
            level_cfg <= `TACC_RST_LEVEL;
            irq_mask <= 3'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `TACC_OFF_CTRL: begin
                    manual <= reg_wdata[`TACC_CTRL_MANUAL];
                    br_off <= reg_wdata[`TACC_CTRL_BR_OFF];
                    timing_mach <= reg_wdata[`TACC_CTRL_TIMING];
                end
                `TACC_OFF_ARM: begin
                    arm_src <= tacc_pkg::tacc_arm_src_t'(reg_wdata[1:0]); // [RQ6]
                    arm_lvl <= reg_wdata[5:4]; // [RQ4]
                end
                `TACC_OFF_POS: begin
                    pos_mode <= tacc_pkg::tacc_pos_t'(reg_wdata[2:0]);
                    user_pos <= reg_wdata[27:16]; // [RQ14]
                end
                `TACC_OFF_DELAY: delay_len <= reg_wdata;
                `TACC_OFF_LEVEL: level_cfg <= reg_wdata[9:0];
                `TACC_OFF_IRQ_MASK: irq_mask <= reg_wdata[2:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port in: two flops, then an edge detect on the settled copy
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
        end else begin
            pin_s1 <= port_in_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Selected arm event; group run never waits
    logic arm_evt;
    always_comb begin
        case (arm_src)
            tacc_pkg::ARM_PORT_IN: arm_evt = pin_s2 && !pin_s3; // [RQ5] [RQ6]
            tacc_pkg::ARM_MACHINE: arm_evt = arm_from_machine; // [RQ6]
            default: arm_evt = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    tacc_pkg::tacc_state_t state;
    logic [1:0] level;
    logic [1:0] last_lvl;
    logic br_hit;
    logic trig_hit;
    logic store_br;
    logic use_delay;
    logic [11:0] post_left;
    logic [31:0] delay_left;
    tacc_pkg::tacc_qual_t qual;

    assign last_lvl = level_cfg[9:8];
    assign qual = level_qual(level_cfg, level);
    assign br_hit = (state == tacc_pkg::ST_SEQ) && smp.valid && smp.level_hit[level];
    assign trig_hit = br_hit && (level == last_lvl);
    // One switch for all branches, honoured only in manual mode
    assign store_br = !(manual && br_off); // [RQ8] [RQ9] [RQ10]
    // Delay is a timing machine choice; a state machine treats it as start
    assign use_delay = manual && timing_mach && (pos_mode == tacc_pkg::POS_DELAY); // [RQ13]

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= tacc_pkg::ST_IDLE;
            level <= 2'h0;
        end else if (run_go) begin
            level <= 2'h0;
            if (arm_src == tacc_pkg::ARM_GROUP_RUN) begin
                state <= tacc_pkg::ST_SEQ; // [RQ1]
            end else begin
                state <= tacc_pkg::ST_WAIT_ARM; // [RQ3]
            end
        end else begin
            case (state)
                tacc_pkg::ST_WAIT_ARM: begin
                    // Matching data is not looked at here
                    if (arm_evt) begin // [RQ3]
                        state <= tacc_pkg::ST_SEQ;
                        level <= arm_lvl; // [RQ4]
                    end
                end
                tacc_pkg::ST_SEQ: begin
                    if (trig_hit) begin
                        state <= use_delay ? tacc_pkg::ST_DELAY : tacc_pkg::ST_POST;
                    end else if (br_hit) begin
                        level <= level + 2'h1;
                    end
                end
                tacc_pkg::ST_DELAY: begin
                    if (delay_left == 32'h0000_0000) begin
                        state <= tacc_pkg::ST_POST; // [RQ13]
                    end
                end
                tacc_pkg::ST_POST: begin
                    // Stop once the last post-trigger sample is in, so End leaves no extra
                    if (post_left == 12'h000) begin
                        state <= tacc_pkg::ST_DONE; // [RQ15]
                    end
                end
                default: ;
            endcase
        end
    end

    // Post-trigger and delay counters
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            post_left <= 12'h000;
            delay_left <= 32'h0000_0000;
        end else if (trig_hit) begin
            post_left <= use_delay ? 12'(`TACC_DEPTH - 13'h001) : post_count(manual, pos_mode,
                                                                        user_pos);
            delay_left <= delay_len;
        end else if (state == tacc_pkg::ST_DELAY) begin
            if (delay_left != 32'h0000_0000) begin
                delay_left <= delay_left - 32'h0000_0001;
            end
        end else if (state == tacc_pkg::ST_POST && smp.valid && post_left != 12'h000) begin
            post_left <= post_left - 12'h001; // [RQ15]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture write: pre-trigger wraps, post-trigger counts down
    logic next_we;
    always_comb begin
        next_we = 1'b0;
        if (state == tacc_pkg::ST_SEQ && smp.valid && !use_delay) begin
            case (qual)
                tacc_pkg::QUAL_ALL: next_we = 1'b1; // [RQ7]
                tacc_pkg::QUAL_SUBSET: next_we = smp.in_subset; // [RQ7]
                default: next_we = 1'b0; // [RQ7]
            endcase
            if (br_hit && (store_br || trig_hit)) begin
                next_we = 1'b1; // [RQ8]
            end
        end else if (state == tacc_pkg::ST_SEQ && trig_hit) begin
            next_we = 1'b0; // [RQ13]
        end else if (state == tacc_pkg::ST_POST && smp.valid && post_left != 12'h000) begin
            next_we = 1'b1;
        end
    end

    logic [11:0] wr_ptr;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cap <= '0;
            wr_ptr <= 12'h000;
            trig_addr <= 12'h000;
        end else begin
            cap.we <= next_we && !run_go;
            cap.addr <= wr_ptr;
            if (run_go) begin
                wr_ptr <= 12'h000;
            end else if (next_we) begin
                wr_ptr <= wr_ptr + 12'h001; // [RQ15]
            end
            if (trig_hit) begin
                trig_addr <= wr_ptr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arm out: one pulse to the other machine and scope, a held edge on port out
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            arm_out <= 1'b0;
            port_out_pin <= 1'b0;
        end else begin
            arm_out <= trig_hit && !run_go; // [RQ2]
            if (run_go) begin
                port_out_pin <= 1'b0;
            end else if (trig_hit) begin
                port_out_pin <= 1'b1; // [RQ2]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over a write-one clear
    logic [2:0] irq_set;
    assign irq_set = {state == tacc_pkg::ST_WAIT_ARM && arm_evt,
                      state == tacc_pkg::ST_POST && post_left == 12'h000,
                      trig_hit};
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_st <= 3'h0;
        end else if (reg_wr && reg_addr == `TACC_OFF_IRQ_ST) begin
            irq_st <= (irq_st & ~reg_wdata[2:0]) | irq_set;
        end else begin
            irq_st <= irq_st | irq_set;
        end
    end
    assign irq = |(irq_st & irq_mask);

    // Read data stand one cycle after the strobe and are zero otherwise
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `TACC_OFF_CTRL: reg_rdata <= {28'h0, timing_mach, br_off, manual, 1'b0};
                `TACC_OFF_ARM: reg_rdata <= {26'h0, arm_lvl, 2'h0, arm_src};
                `TACC_OFF_POS: reg_rdata <= {4'h0, user_pos, 13'h0, pos_mode};
                `TACC_OFF_DELAY: reg_rdata <= delay_len;
                `TACC_OFF_LEVEL: reg_rdata <= {22'h0, level_cfg};
                `TACC_OFF_STATUS: reg_rdata <= {trig_addr, post_left, 3'h0, level, state};
                `TACC_OFF_IRQ_ST: reg_rdata <= {29'h0, irq_st};
                `TACC_OFF_IRQ_MASK: reg_rdata <= {29'h0, irq_mask};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_run_starts_seq: assert property ( // [RQ1]
        run_go && arm_src == tacc_pkg::ARM_GROUP_RUN |=> state == tacc_pkg::ST_SEQ && level == 2'h0)
        else $error("run did not start the sequence");
    a_trig_sends_arm: assert property ( // [RQ2]
        trig_hit && !run_go |=> arm_out && port_out_pin ##1 !arm_out && port_out_pin)
        else $error("arm not sent on trigger");
    a_wait_ignores_data: assert property ( // [RQ3]
        state == tacc_pkg::ST_WAIT_ARM && !arm_evt && !run_go |=> !arm_out && !cap.we
        && state == tacc_pkg::ST_WAIT_ARM)
        else $error("data acted on before arm");
    a_arm_sets_level: assert property ( // [RQ4]
        state == tacc_pkg::ST_WAIT_ARM && arm_evt && !run_go
        |=> state == tacc_pkg::ST_SEQ && level == $past(arm_lvl))
        else $error("arm entered wrong level");
    a_port_rise_arms: assert property ( // [RQ5]
        state == tacc_pkg::ST_WAIT_ARM && arm_src == tacc_pkg::ARM_PORT_IN && !run_go
        && $rose(pin_s2) |=> state == tacc_pkg::ST_SEQ)
        else $error("port rising edge missed");
    a_machine_arms: assert property ( // [RQ6]
        state == tacc_pkg::ST_WAIT_ARM && arm_src == tacc_pkg::ARM_MACHINE && !run_go
        && arm_from_machine |=> state == tacc_pkg::ST_SEQ)
        else $error("machine arm missed");
    a_qual_none_drops: assert property ( // [RQ7]
        state == tacc_pkg::ST_SEQ && smp.valid && qual == tacc_pkg::QUAL_NONE && !br_hit
        && !run_go |=> !cap.we)
        else $error("sample stored under none qualifier");
    a_branch_stored: assert property ( // [RQ8]
        br_hit && !manual && !use_delay && !run_go |=> cap.we)
        else $error("branch sample not stored");
    a_start_post_count: assert property ( // [RQ12]
        trig_hit && manual && pos_mode == tacc_pkg::POS_START && !run_go
        |=> post_left == 12'hFFF)
        else $error("start position count wrong");
    a_delay_discards: assert property ( // [RQ13]
        state == tacc_pkg::ST_DELAY |=> !cap.we)
        else $error("sample kept during delay");
    a_post_ends_done: assert property ( // [RQ15]
        state == tacc_pkg::ST_POST && post_left == 12'h000 && !run_go
        |=> state == tacc_pkg::ST_DONE && !cap.we)
        else $error("capture did not stop");
endmodule : tacc_arm_capture

// >>> tb/tacc_arm_partner.sv
`timescale 1ns/1ps
module tacc_arm_partner (
    // Clock
    input wire logic ref_clk,
    // Commands from the bench
    input wire logic fire,
    input wire logic [3:0] hold,
    // Lines to and from the analyzer
    input wire logic port_out_pin,
    output logic port_in_pin,
    output logic [7:0] edges_seen
);
    logic [3:0] left;
    logic last_out;

    initial begin
        port_in_pin = 1'b0;
        left = 4'h0;
        last_out = 1'b0;
        edges_seen = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Rising edge held for hold plus one cycles; a short hold tests the synchroniser margin
    always @(posedge ref_clk) begin
        if (fire) begin
            port_in_pin <= 1'b1;
            left <= hold;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end else begin
            port_in_pin <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counts the trigger edges that arrive on the output port
    always @(posedge ref_clk) begin
        last_out <= port_out_pin;
        if (port_out_pin && !last_out) begin
            edges_seen <= edges_seen + 8'h01;
        end
    end
endmodule : tacc_arm_partner

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    tacc_pkg::tacc_smp_t smp = '0;
    logic port_in_pin;
    logic arm_from_machine = 1'b0;
    logic arm_out;
    logic port_out_pin;
    tacc_pkg::tacc_cap_t cap;
    logic [11:0] trig_addr;
    logic irq;
    logic fire = 1'b0;
    logic [3:0] hold = 4'h3;
    logic [7:0] edges_seen;
    logic [31:0] rv;
    logic [31:0] rst_exp [0:8] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h3FF, 32'h0, 32'h0, 32'h0, 32'h0};
    integer err_total = 0;
    integer comparisons = 0;
    integer seed = 92;
    integer we_cnt = 0;
    integer base;
    integer i;
    integer n;
    integer trigs = 0;
    integer arm_cnt = 0;

    always #2 ref_clk = ~ref_clk;

    tacc_arm_capture DUT (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .smp(smp), .port_in_pin(port_in_pin), .arm_from_machine(arm_from_machine),
        .arm_out(arm_out), .port_out_pin(port_out_pin), .cap(cap), .trig_addr(trig_addr),
        .irq(irq));

    tacc_arm_partner far_end (.ref_clk(ref_clk), .fire(fire), .hold(hold),
        .port_out_pin(port_out_pin), .port_in_pin(port_in_pin), .edges_seen(edges_seen));

    ////////////////////////////////////////////////////////////////////////////////
    // Stored samples, counted at the edge after each write pulse
    always @(posedge ref_clk) begin
        if (cap.we === 1'b1) begin
            we_cnt = we_cnt + 1;
        end
        if (arm_out === 1'b1) begin
            arm_cnt = arm_cnt + 1;
        end
    end

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task final_report;
        $display("Comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task samp(input logic [3:0] hit, input logic sub);
        @(posedge ref_clk);
        smp <= {1'b1, sub, hit};
        @(posedge ref_clk);
        smp <= '0;
    endtask : samp

    // Sample that completes the sequence; arm must be a single-cycle pulse
    task trig(input logic [3:0] hit);
        samp(hit, 1'b0);
        #1;
        chk("arm_out", 32'h1, {31'h0, arm_out});
        chk("port_out_pin", 32'h1, {31'h0, port_out_pin});
        @(posedge ref_clk);
        #1;
        chk("arm_out width", 32'h0, {31'h0, arm_out});
        trigs = trigs + 1;
    endtask : trig

    // Trigger, then a fixed n plus three samples; stored count and done flag checked
    task post(input logic [31:0] ctrl, input logic [31:0] pos, input integer exp,
              input logic done);
        wr(8'h08, pos);
        wr(8'h18, 32'h7);
        wr(8'h00, ctrl);
        base = we_cnt;
        trig(4'h1);
        for (i = 0; i < n + 3; i++) begin
            samp(4'h0, 1'b0);
        end
        @(posedge ref_clk);
        #1;
        chk("stored after trigger", exp, we_cnt - base);
        rd(8'h18, rv);
        chk("capture done", {31'h0, done}, {31'h0, rv[1]});
    endtask : post

    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        chk("run length", 32'h0, 32'h1);
        final_report;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        for (int k = 0; k < 9; k++) begin
            rd(8'(k * 4), rv);
            chk("reset value", rst_exp[k], rv);
        end
        // Group run, single level, interrupt unmasked then cleared
        wr(8'h10, 32'h55);
        wr(8'h1C, 32'h7);
        wr(8'h00, 32'h1);
        trig(4'h1);
        chk("trig_addr", 32'h0, {20'h0, trig_addr});
        chk("cap addr", 32'h1, {20'h0, cap.addr});
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(8'h18, 32'h1);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Arm from another machine into level 1; matches ignored meanwhile
        wr(8'h1C, 32'h0);
        wr(8'h10, 32'h155);
        wr(8'h18, 32'h7);
        wr(8'h04, 32'h12);
        wr(8'h00, 32'h1);
        base = we_cnt;
        n = arm_cnt;
        for (i = 0; i < 5; i++) begin
            samp(4'($random(seed)), 1'($random(seed)));
        end
        chk("stored while waiting", base, we_cnt);
        chk("trigger while waiting", n, arm_cnt);
        @(posedge ref_clk);
        arm_from_machine <= 1'b1;
        @(posedge ref_clk);
        arm_from_machine <= 1'b0;
        samp(4'h1, 1'b0);
        #1;
        chk("arm at level 0 hit", 32'h0, {31'h0, arm_out});
        trig(4'h2);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(8'h18, rv);
        chk("irq status", 32'h5, rv & 32'h7);
        // Arm through the external port
        wr(8'h18, 32'h7);
        wr(8'h04, 32'h11);
        wr(8'h00, 32'h1);
        @(posedge ref_clk);
        fire <= 1'b1;
        hold <= 4'($random(seed)) | 4'h2;
        @(posedge ref_clk);
        fire <= 1'b0;
        rv = 32'h0;
        for (i = 0; i < 20 && rv[2] !== 1'b1; i++) begin
            rd(8'h18, rv);
        end
        chk("port arm seen", 32'h1, {31'h0, rv[2]});
        if (rv[2] !== 1'b1) begin
            final_report;
        end
        trig(4'h2);
        // Trigger placement and post-trigger counts, back on group run
        wr(8'h04, 32'h0);
        wr(8'h10, 32'h55);
        n = ($random(seed) & 3) + 1;
        post(32'h3, {4'h0, 12'(n), 13'h0, 3'h4}, n + 1, 1'b1);
        post(32'h3, 32'h2, 1, 1'b1);
        post(32'h3, 32'h0, n + 4, 1'b0);
        post(32'h1, 32'h2, n + 4, 1'b0);
        // Delay position on a timing machine
        wr(8'h0C, 32'h4);
        wr(8'h08, 32'h3);
        wr(8'h00, 32'hB);
        base = we_cnt;
        trig(4'h1);
        samp(4'h0, 1'b0);
        repeat (8) @(posedge ref_clk);
        samp(4'h0, 1'b0);
        samp(4'h0, 1'b0);
        @(posedge ref_clk);
        #1;
        // The trigger sample falls inside the delay and is dropped as well
        chk("stored around delay", 32'd2, we_cnt - base);
        // Qualifiers and branch storing, on then off
        wr(8'h08, 32'h1);
        wr(8'h10, 32'h108);
        for (n = 0; n < 2; n++) begin
            wr(8'h00, n == 0 ? 32'h1 : 32'h7);
            base = we_cnt;
            samp(4'h0, 1'b0);
            samp(4'h1, 1'b0);
            samp(4'h0, 1'b1);
            samp(4'h0, 1'b0);
            @(posedge ref_clk);
            #1;
            chk("qualified stores", 2 - n, we_cnt - base);
        end
        chk("edges at far end", trigs, {24'h0, edges_seen});
        chk("arm pulses", trigs, arm_cnt);
        final_report;
    end
endmodule : testbench
